// >>> rtl/serial_port_map.vh
// Contract
// - rank line status, data, thr empty, modem
// - identification value frozen during its access
// - bit 0 low when enabled interrupt pending
// - encode top source in identification bits 3..0
// - bit 3 only for timeout in fifo mode
// - identification bits 4 and 5 read zero
// - bits 6,7 follow fifo enable bit
// - fifo timeout after 4 idle char times
// - thr empty cleared by identification read, thr write
// - line format bits 1..0 give word length
// - bit 2 selects 1, 1.5 or 2 stops
// - receiver checks only first stop bit
// - parity bit after data when bit 3 set
// - bit 4 selects even, else odd parity
// - stick parity sends inverse of bit 4
// - bit 6 forces transmit output low
// - bit 7 maps offsets 0,1 to divisor
// - terminal ready low when modem bit 0 set
// - request to send low when modem bit 1
// - low four enable bits gate each class
// - interrupt pin driven only while modem bit 3
// - fifo enable bit enters or leaves fifo mode
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
// register indices, byte address is four times the index
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_IIR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SCR 3'h7
// identification codes
`define IIR_NONE 4'h1
`define IIR_LS 4'h6
`define IIR_RDA 4'h4
`define IIR_TMO 4'hC
`define IIR_THRE 4'h2
`define IIR_MS 4'h0
`define IIR_FIFO_ON 2'h3
// field positions
`define LCR_STB 2
`define LCR_PEN 3
`define LCR_EPS 4
`define LCR_STICK 5
`define LCR_BRK 6
`define LCR_DIVISOR_LATCH_SELECT 7
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_IRQ_OUTPUT_ENABLE 3
`define IER_RDA 0
`define IER_THRE 1
`define IER_LS 2
`define IER_MS 3
`define FCR_EN 0
`define FCR_RXCLR 1
`define FCR_TXCLR 2
// reset values
`define LCR_RESET 8'h00
`define MCR_RESET 5'h00
`define IER_RESET 4'h0
`define DIV_RESET 16'h0001
`define MDM_IDLE 4'hF
// receive trigger levels in characters
`define TRIG_L0 5'h01
`define TRIG_L1 5'h04
`define TRIG_L2 5'h08
`define TRIG_L3 5'h0E
// timing in 16x oversample ticks
`define HALF_LAST 4'h7
`define SAMPLE_LAST 4'hF
`define BIT_LAST 6'h0F
`define STOP15_LAST 6'h17
`define STOP2_LAST 6'h1F
// timeout: 4 character times of 16 ticks per bit
`define TO_TICKS_PER_BIT 10'h040
`define START_BITS 4'h1
`define MIN_WORD 4'h5
`endif

// >>> rtl/serial_tx_frame.v
`timescale 1ns/10ps
`include "serial_port_map.vh"
module serial_tx_frame (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // 16x bit tick and format bits 5..0 of line format control
  input wire tick_in,
  input wire [5:0] fmt_in,
  // character handshake
  input wire [7:0] data_in,
  input wire valid_in,
  output reg take_out,
  // line
  output reg ser_out,
  output wire busy_out
);
  localparam TX_IDLE = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA = 3'h2;
  localparam TX_PAR = 3'h3;
  localparam TX_STOP = 3'h4;
  reg [2:0] st_r;
  reg [5:0] tk_r;
  reg [2:0] bit_r;
  reg [7:0] sh_r;
  reg par_r;
  reg [7:0] mask;
  reg [7:0] dm;
  reg par_nxt;
  wire [2:0] bit_last = 3'h4 + {1'b0, fmt_in[1:0]};
  wire [5:0] stop_last = !fmt_in[`LCR_STB] ? `BIT_LAST :
    (fmt_in[1:0] == 2'h0) ? `STOP15_LAST : `STOP2_LAST;
  assign busy_out = (st_r != TX_IDLE);

  always @*
  begin
    case (fmt_in[1:0])
      2'h0: mask = 8'h1F;
      2'h1: mask = 8'h3F;
      2'h2: mask = 8'h7F;
      default: mask = 8'hFF;
    endcase
    dm = data_in & mask;
    if (fmt_in[`LCR_STICK])
      par_nxt = ~fmt_in[`LCR_EPS];
    else if (fmt_in[`LCR_EPS])
      par_nxt = ^dm;
    else
      par_nxt = ~^dm;
  end

  always @*
  begin
    case (st_r)
      TX_START: ser_out = 1'h0;
      TX_DATA: ser_out = sh_r[0];
      TX_PAR: ser_out = par_r;
      default: ser_out = 1'h1;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= TX_IDLE;
      tk_r <= 6'h00;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      par_r <= 1'h0;
      take_out <= 1'h0;
    end
    else
    begin
      take_out <= 1'h0;
      case (st_r)
        TX_IDLE:
          if (valid_in && !take_out)
          begin
            take_out <= 1'h1;
            sh_r <= data_in;
            par_r <= par_nxt;
            tk_r <= 6'h00;
            st_r <= TX_START;
          end
        TX_START:
          if (tick_in)
          begin
            tk_r <= (tk_r == `BIT_LAST) ? 6'h00 : tk_r + 6'h01;
            if (tk_r == `BIT_LAST)
            begin
              bit_r <= 3'h0;
              st_r <= TX_DATA;
            end
          end
        TX_DATA:
          if (tick_in)
          begin
            tk_r <= (tk_r == `BIT_LAST) ? 6'h00 : tk_r + 6'h01;
            if (tk_r == `BIT_LAST)
            begin
              sh_r <= {1'h0, sh_r[7:1]};
              bit_r <= bit_r + 3'h1;
              if (bit_r == bit_last)
                st_r <= fmt_in[`LCR_PEN] ? TX_PAR : TX_STOP;
            end
          end
        TX_PAR:
          if (tick_in)
          begin
            tk_r <= (tk_r == `BIT_LAST) ? 6'h00 : tk_r + 6'h01;
            if (tk_r == `BIT_LAST)
              st_r <= TX_STOP;
          end
        TX_STOP:
          if (tick_in)
          begin
            tk_r <= tk_r + 6'h01;
            if (tk_r == stop_last)
            begin
              tk_r <= 6'h00;
              st_r <= TX_IDLE;
            end
          end
        default:
          st_r <= TX_IDLE;
      endcase
    end
  end
endmodule

// >>> rtl/serial_port.v
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "serial_port_map.vh"
module serial_port #(
  parameter DEPTH = 16,
  parameter PTR_W = 4,
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire ref_clk_in,
  input wire nrst_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // serial line
  input wire rxd_in,
  output reg txd_out,
  // modem lines
  input wire cts_n_in,
  input wire dsr_n_in,
  input wire ri_n_in,
  input wire dcd_n_in,
  output reg terminal_ready_n_out,
  output reg request_to_send_n_out,
  // interrupt pin with its enable
  output reg irq_out,
  output reg irq_oe_out
);
  localparam [PTR_W:0] DEPTH_N = DEPTH;
  localparam [PTR_W:0] ONE_N = 1;
  localparam RX_IDLE = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA = 3'h2;
  localparam RX_PAR = 3'h3;
  localparam RX_STOP = 3'h4;
  localparam RX_WAIT = 3'h5;

  function [3:0] iir_code;
    input ls, rda, tmo, thre, ms;
    begin
      if (ls)
        iir_code = `IIR_LS;
      else if (rda)
        iir_code = `IIR_RDA;
      else if (tmo)
        iir_code = `IIR_TMO;
      else if (thre)
        iir_code = `IIR_THRE;
      else if (ms)
        iir_code = `IIR_MS;
      else
        iir_code = `IIR_NONE;
    end
  endfunction

  function [4:0] trig_level;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: trig_level = `TRIG_L0;
        2'h1: trig_level = `TRIG_L1;
        2'h2: trig_level = `TRIG_L2;
        default: trig_level = `TRIG_L3;
      endcase
    end
  endfunction

  reg rst_meta_r;
  reg rst_n;
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_r <= 1'h0;
      rst_n <= 1'h0;
    end
    else
    begin
      rst_meta_r <= 1'h1;
      rst_n <= rst_meta_r;
    end
  end

  reg [7:0] lcr_r;
  reg [4:0] mcr_r;
  reg [3:0] ier_r;
  reg [7:0] scr_r;
  reg [15:0] div_r;
  reg fifo_en_r;
  reg [1:0] trig_r;
  reg [3:0] iir_hold_r;
  reg [3:0] lsr_err_r;
  reg [3:0] mdm_prev_r;
  reg [3:0] delta_r;
  reg thre_pend_r;
  reg tx_empty_d_r;
  reg to_r;
  reg [9:0] to_cnt_r;
  reg [15:0] bd_cnt_r;
  reg tick_r;

  // bus decode; offsets are word indices
  wire [2:0] idx = paddr_in[4:2];
  wire addr_ok = (paddr_in[1:0] == 2'h0) && ~|paddr_in[ADDR_W-1:5];
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in & pready_out & ~pslverr_out;
  wire wr = access & pwrite_in;
  wire rd = access & ~pwrite_in;
  wire divisor_latch_select = lcr_r[`LCR_DIVISOR_LATCH_SELECT];
  wire wr_thr = wr && idx == `OFS_DATA && !divisor_latch_select;
  wire rd_rbr = rd && idx == `OFS_DATA && !divisor_latch_select;
  wire wr_ier = wr && idx == `OFS_IER && !divisor_latch_select;
  wire wr_fcr = wr && idx == `OFS_IIR;
  wire rd_iir = rd && idx == `OFS_IIR;
  wire rd_lsr = rd && idx == `OFS_LSR;
  wire rd_msr = rd && idx == `OFS_MSR;
  wire fcr_mode_chg = wr_fcr && (pwdata_in[`FCR_EN] != fifo_en_r);
  wire rx_clr = wr_fcr && (pwdata_in[`FCR_RXCLR] || fcr_mode_chg);
  wire tx_clr = wr_fcr && (pwdata_in[`FCR_TXCLR] || fcr_mode_chg);

  // receive queue holds {break, framing, parity, data}
  reg [10:0] rxq [0:DEPTH-1];
  reg [PTR_W-1:0] rx_wp_r;
  reg [PTR_W-1:0] rx_rp_r;
  reg [PTR_W:0] rx_cnt_r;
  reg rx_done_r;
  reg [10:0] rx_word_r;
  wire [PTR_W:0] cap = fifo_en_r ? DEPTH_N : ONE_N;
  wire rx_full = (rx_cnt_r == cap);
  wire rx_pop = rd_rbr && rx_cnt_r != 0;
  wire rx_push = rx_done_r && !rx_full && !rx_clr;
  wire [10:0] rx_top = rxq[rx_rp_r];

  always @(posedge ref_clk_in)
  begin
    if (rx_push)
      rxq[rx_wp_r] <= rx_word_r;
  end

  always @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_wp_r <= {PTR_W{1'h0}};
      rx_rp_r <= {PTR_W{1'h0}};
      rx_cnt_r <= {(PTR_W+1){1'h0}};
    end
    else if (rx_clr)
    begin
      rx_wp_r <= {PTR_W{1'h0}};
      rx_rp_r <= {PTR_W{1'h0}};
      rx_cnt_r <= {(PTR_W+1){1'h0}};
    end
    else
    begin
      if (rx_push)
        rx_wp_r <= rx_wp_r + 1'h1;
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 1'h1;
      if (rx_push && !rx_pop)
        rx_cnt_r <= rx_cnt_r + 1'h1;
      else if (rx_pop && !rx_push)
        rx_cnt_r <= rx_cnt_r - 1'h1;
    end
  end

  // transmit queue feeding the frame builder
  reg [7:0] txq [0:DEPTH-1];
  reg [PTR_W-1:0] tx_wp_r;
  reg [PTR_W-1:0] tx_rp_r;
  reg [PTR_W:0] tx_cnt_r;
  wire tx_take;
  wire tx_busy;
  wire tx_ser;
  wire tx_empty = (tx_cnt_r == 0);
  wire tx_push = wr_thr && tx_cnt_r != cap && !tx_clr;
  wire tx_pop = tx_take && !tx_empty && !tx_clr;

  always @(posedge ref_clk_in)
  begin
    if (tx_push)
      txq[tx_wp_r] <= pwdata_in[7:0];
  end

  always @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp_r <= {PTR_W{1'h0}};
      tx_rp_r <= {PTR_W{1'h0}};
      tx_cnt_r <= {(PTR_W+1){1'h0}};
    end
    else if (tx_clr)
    begin
      tx_wp_r <= {PTR_W{1'h0}};
      tx_rp_r <= {PTR_W{1'h0}};
      tx_cnt_r <= {(PTR_W+1){1'h0}};
    end
    else
    begin
      if (tx_push)
        tx_wp_r <= tx_wp_r + 1'h1;
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 1'h1;
      if (tx_push && !tx_pop)
        tx_cnt_r <= tx_cnt_r + 1'h1;
      else if (tx_pop && !tx_push)
        tx_cnt_r <= tx_cnt_r - 1'h1;
    end
  end

  serial_tx_frame u_tx (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .tick_in(tick_r),
    .fmt_in(lcr_r[5:0]),
    .data_in(txq[tx_rp_r]),
    .valid_in(!tx_empty),
    .take_out(tx_take),
    .ser_out(tx_ser),
    .busy_out(tx_busy)
  );

  // divisor of zero behaves as one so the tick never stops
  wire [15:0] div_last = (div_r == 16'h0000) ? 16'h0000 : div_r - 16'h0001;
  always @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bd_cnt_r <= 16'h0000;
      tick_r <= 1'h0;
    end
    else
    begin
      tick_r <= (bd_cnt_r >= div_last);
      bd_cnt_r <= (bd_cnt_r >= div_last) ? 16'h0000 : bd_cnt_r + 16'h0001;
    end
  end

  // receiver, sampled at bit centres
  reg [2:0] rx_st_r;
  reg [3:0] rx_tk_r;
  reg [2:0] rx_bit_r;
  reg [7:0] rx_sh_r;
  reg rx_pe_r;
  reg rx_zero_r;
  wire [2:0] rx_bit_last = 3'h4 + {1'b0, lcr_r[1:0]};
  wire [7:0] rx_mask = 8'hFF >> (2'h3 - lcr_r[1:0]);
  wire [7:0] rx_dm = rx_sh_r & rx_mask;
  wire rx_exp = lcr_r[`LCR_STICK] ? ~lcr_r[`LCR_EPS] :
    (lcr_r[`LCR_EPS] ? ^rx_dm : ~^rx_dm);

  always @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_r <= RX_IDLE;
      rx_tk_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_pe_r <= 1'h0;
      rx_zero_r <= 1'h0;
      rx_done_r <= 1'h0;
      rx_word_r <= 11'h000;
    end
    else
    begin
      rx_done_r <= 1'h0;
      if (tick_r)
      begin
        rx_tk_r <= rx_tk_r + 4'h1;
        case (rx_st_r)
          RX_IDLE:
          begin
            rx_tk_r <= 4'h0;
            if (!rxd_in)
              rx_st_r <= RX_START;
          end
          RX_START:
            if (rx_tk_r == `HALF_LAST)
            begin
              rx_tk_r <= 4'h0;
              rx_bit_r <= 3'h0;
              rx_sh_r <= 8'h00;
              rx_pe_r <= 1'h0;
              rx_zero_r <= 1'h1;
              rx_st_r <= rxd_in ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_tk_r == `SAMPLE_LAST)
            begin
              rx_sh_r[rx_bit_r] <= rxd_in;
              rx_zero_r <= rx_zero_r & ~rxd_in;
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == rx_bit_last)
                rx_st_r <= lcr_r[`LCR_PEN] ? RX_PAR : RX_STOP;
            end
          RX_PAR:
            if (rx_tk_r == `SAMPLE_LAST)
            begin
              rx_pe_r <= rxd_in ^ rx_exp;
              rx_zero_r <= rx_zero_r & ~rxd_in;
              rx_st_r <= RX_STOP;
            end
          RX_STOP:
            if (rx_tk_r == `SAMPLE_LAST)
            begin
              // a break loads one zero character
              rx_done_r <= 1'h1;
              rx_word_r <= {rx_zero_r & ~rxd_in, ~rxd_in, rx_pe_r, rx_dm};
              rx_st_r <= rxd_in ? RX_IDLE : RX_WAIT;
            end
          RX_WAIT:
            if (rxd_in)
              rx_st_r <= RX_IDLE;
          default:
            rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end

  // character timeout
  wire [3:0] frame_bits = `START_BITS + `MIN_WORD + {2'h0, lcr_r[1:0]} +
    {3'h0, lcr_r[`LCR_PEN]} + (lcr_r[`LCR_STB] ? 4'h2 : 4'h1);
  wire [9:0] to_limit = {6'h00, frame_bits} * `TO_TICKS_PER_BIT;
  wire to_run = fifo_en_r && rx_cnt_r != 0 && !rx_push && !rx_pop;
  wire to_fire = to_run && to_cnt_r == to_limit;

  // interrupt sources, each gated by its enable
  wire ls_int = ier_r[`IER_LS] & |lsr_err_r;
  wire rda_int = ier_r[`IER_RDA] & (fifo_en_r ?
    (rx_cnt_r >= trig_level(trig_r)) : (rx_cnt_r != 0));
  wire to_int = ier_r[`IER_RDA] & fifo_en_r & to_r;
  wire thre_int = ier_r[`IER_THRE] & thre_pend_r;
  wire ms_int = ier_r[`IER_MS] & |delta_r;
  wire [3:0] code = iir_code(ls_int, rda_int, to_int, thre_int, ms_int);
  wire [7:0] iir_val = {fifo_en_r ? `IIR_FIFO_ON : 2'h0, 2'h0, code};
  wire [3:0] mdm_now = {dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
  wire [3:0] mdm_chg = {mdm_prev_r[3] ^ mdm_now[3], ~mdm_prev_r[2] & mdm_now[2],
    mdm_prev_r[1:0] ^ mdm_now[1:0]};
  wire [3:0] err_set = {rx_push & rx_word_r[10], rx_push & rx_word_r[9],
    rx_push & rx_word_r[8], rx_done_r & rx_full};
  wire thre_set = (tx_empty & ~tx_empty_d_r) |
    (wr_ier & pwdata_in[`IER_THRE] & ~ier_r[`IER_THRE] & tx_empty);
  wire thre_clr = wr_thr | (rd_iir & iir_hold_r == `IIR_THRE);

  reg [7:0] rd_mux;
  always @*
  begin
    case (idx)
      `OFS_DATA: rd_mux = divisor_latch_select ? div_r[7:0] : rx_top[7:0];
      `OFS_IER: rd_mux = divisor_latch_select ? div_r[15:8] : {4'h0, ier_r};
      `OFS_IIR: rd_mux = iir_val;
      `OFS_LCR: rd_mux = lcr_r;
      `OFS_MCR: rd_mux = {3'h0, mcr_r};
      `OFS_LSR: rd_mux = {fifo_en_r & |lsr_err_r[3:1], tx_empty & ~tx_busy,
        tx_empty, lsr_err_r, rx_cnt_r != 0};
      `OFS_MSR: rd_mux = {~mdm_now, delta_r};
      default: rd_mux = scr_r;
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lcr_r <= `LCR_RESET;
      mcr_r <= `MCR_RESET;
      ier_r <= `IER_RESET;
      scr_r <= 8'h00;
      div_r <= `DIV_RESET;
      fifo_en_r <= 1'h0;
      trig_r <= 2'h0;
      iir_hold_r <= `IIR_NONE;
      lsr_err_r <= 4'h0;
      mdm_prev_r <= `MDM_IDLE;
      delta_r <= 4'h0;
      thre_pend_r <= 1'h0;
      tx_empty_d_r <= 1'h1;
      to_r <= 1'h0;
      to_cnt_r <= 10'h000;
      prdata_out <= 32'h00000000;
      pready_out <= 1'h0;
      pslverr_out <= 1'h0;
      txd_out <= 1'h1;
      terminal_ready_n_out <= 1'h1;
      request_to_send_n_out <= 1'h1;
      irq_out <= 1'h0;
      irq_oe_out <= 1'h0;
    end
    else
    begin
      pready_out <= setup;
      pslverr_out <= setup & ~addr_ok;
      // the snapshot taken at setup is what the access returns
      if (setup)
      begin
        prdata_out <= {24'h000000, rd_mux};
        iir_hold_r <= code;
      end
      if (wr)
      begin
        case (idx)
          `OFS_DATA:
            if (divisor_latch_select)
              div_r[7:0] <= pwdata_in[7:0];
          `OFS_IER:
            if (divisor_latch_select)
              div_r[15:8] <= pwdata_in[7:0];
            else
              ier_r <= pwdata_in[3:0];
          `OFS_IIR:
          begin
            fifo_en_r <= pwdata_in[`FCR_EN];
            if (pwdata_in[`FCR_EN])
              trig_r <= pwdata_in[7:6];
          end
          `OFS_LCR: lcr_r <= pwdata_in[7:0];
          `OFS_MCR: mcr_r <= pwdata_in[4:0];
          `OFS_SCR: scr_r <= pwdata_in[7:0];
          default: scr_r <= scr_r;
        endcase
      end
      // new events win over a clearing read in the same cycle
      lsr_err_r <= (rd_lsr ? 4'h0 : lsr_err_r) | err_set;
      mdm_prev_r <= mdm_now;
      delta_r <= (rd_msr ? 4'h0 : delta_r) | mdm_chg;
      tx_empty_d_r <= tx_empty;
      thre_pend_r <= thre_set | (thre_pend_r & ~thre_clr);
      if (!to_run)
        to_cnt_r <= 10'h000;
      else if (tick_r && to_cnt_r != to_limit)
        to_cnt_r <= to_cnt_r + 10'h001;
      to_r <= to_fire | (to_r & ~(rx_pop | rx_push | rx_clr | ~fifo_en_r));
      txd_out <= lcr_r[`LCR_BRK] ? 1'h0 : tx_ser;
      terminal_ready_n_out <= ~mcr_r[`MCR_DTR];
      request_to_send_n_out <= ~mcr_r[`MCR_RTS];
      irq_out <= ~code[0];
      irq_oe_out <= mcr_r[`MCR_IRQ_OUTPUT_ENABLE];
    end
  end
endmodule

// >>> tb/serial_port_asserts.sv
`timescale 1ns/10ps
module serial_port_asserts #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire ref_clk_in,
  input wire nrst_in,
  // apb
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  // lines
  input wire txd_out,
  input wire terminal_ready_n_out,
  input wire request_to_send_n_out,
  input wire irq_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  wire done = psel_in && penable_in && pready_out;
  wire ctl_wr = done && pwrite_in && paddr_in == 8'h10;
  wire fmt_wr = done && pwrite_in && paddr_in == 8'h0C;
  wire id_rd = done && !pwrite_in && paddr_in == 8'h08;
  a_ready_line_follows: assert property (ctl_wr |=> ##1 terminal_ready_n_out == !$past(pwdata_in[0], 2))
    else $error("terminal ready does not follow control bit 0");
  a_send_req_follows: assert property (ctl_wr |=> ##1 request_to_send_n_out == !$past(pwdata_in[1], 2))
    else $error("request to send does not follow control bit 1");
  a_irq_pin_enable: assert property (ctl_wr |=> ##1 irq_oe_out == $past(pwdata_in[3], 2))
    else $error("interrupt pin enable does not follow control bit 3");
  a_break_forces_low: assert property (fmt_wr && pwdata_in[6] |=> ##[1:3] !txd_out)
    else $error("break does not force transmit low");
  a_id_upper_zero: assert property (id_rd |-> prdata_out[5:4] == 2'h0)
    else $error("identification bits 5:4 not zero");
  a_id_code_legal: assert property (id_rd |-> prdata_out[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hC})
    else $error("identification code not a legal source code");
  a_id_none_code: assert property (id_rd && prdata_out[0] |-> prdata_out[3:1] == 3'h0)
    else $error("bit 0 set with a source code");
  a_id_fifo_pair: assert property (id_rd |-> prdata_out[7] == prdata_out[6] && (!prdata_out[3] || prdata_out[2] && prdata_out[7]))
    else $error("fifo mode bits or timeout bit inconsistent");
  a_id_frozen: assert property (id_rd |=> $stable(prdata_out))
    else $error("identification value changed during access");
endmodule

// >>> tb/modem_peer.sv
`timescale 1ns/10ps
module modem_peer (
  input wire clk_in,
  input wire txd_in,
  output reg rxd_out,
  output reg cts_n_out
);
  // lines idle at mark level, as with the usual pull-up
  initial
  begin
    rxd_out = 1'b1;
    cts_n_out = 1'b1;
  end
  // lsb first, 16 clocks a bit at divisor 1
  task send(input [11:0] bits, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        @(posedge clk_in);
        rxd_out <= bits[i];
        repeat (15) @(posedge clk_in);
      end
    end
  endtask
  // only the first stop bit is sampled
  task grab(input integer n, output [11:0] bits);
    integer i;
    integer w;
    begin
      bits = 12'h000;
      w = 0;
      while (txd_in !== 1'b0 && w < 3000)
      begin
        @(posedge clk_in);
        w = w + 1;
      end
      repeat (8) @(posedge clk_in);
      for (i = 0; i < n; i = i + 1)
      begin
        bits[i] = txd_in;
        repeat (16) @(posedge clk_in);
      end
    end
  endtask
endmodule

// >>> tb/serial_port_tb.sv
`timescale 1ns/10ps
module serial_port_tb;
  reg ref_clk_in;
  reg nrst_in;
  reg psel, penable, pwrite, serr;
  reg [7:0] paddr;
  reg [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, rxd, txd, tr_n, rq_n, irq, irq_oe, cts_n;
  reg [11:0] bits, e;
  reg [7:0] fmt [0:3];
  integer err_count, check_count, cyc, i, n, nb;
  serial_port #(.ADDR_W(8)) serial_port_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd), .txd_out(txd),
    .cts_n_in(cts_n), .dsr_n_in(1'b1), .ri_n_in(1'b1), .dcd_n_in(1'b1),
    .terminal_ready_n_out(tr_n), .request_to_send_n_out(rq_n), .irq_out(irq),
    .irq_oe_out(irq_oe));
  modem_peer modem_peer_i (.clk_in(ref_clk_in), .txd_in(txd), .rxd_out(rxd), .cts_n_out(cts_n));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      err_count = err_count + 1;
      test_done;
    end
  end
  // request held until pready is seen high at a rising edge
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge ref_clk_in);
      penable <= 1'b1;
      @(posedge ref_clk_in);
      while (pready !== 1'b1)
        @(posedge ref_clk_in);
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input string nm);
    begin
      apb(1'b0, a, 8'h00);
      chk(nm, {24'h000000, exp}, q);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, d);
  endtask
  task idle(input integer c);
    repeat (c) @(posedge ref_clk_in);
  endtask
  // whole frame from start to first stop bit; nb gets its length
  function [11:0] frame(input [7:0] f, input [7:0] d);
    integer k;
    reg p;
    begin
      frame = 12'h000;
      p = !f[4];
      for (k = 1; k < 6 + f[1:0]; k = k + 1)
      begin
        frame[k] = d[k-1];
        p = p ^ d[k-1];
      end
      if (f[3])
      begin
        frame[k] = f[5] ? !f[4] : p;
        k = k + 1;
      end
      frame[k] = 1'b1;
      nb = k + 1;
    end
  endfunction
  initial
  begin
    nrst_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    fmt[0] = 8'h00;
    fmt[1] = 8'h1B;
    fmt[2] = 8'h0A;
    fmt[3] = 8'h2F;
    idle(6);
    nrst_in <= 1'b1;
    idle(4);
    rd(8'h0C, 8'h00, "format reset");
    rd(8'h08, 8'h01, "ident reset");
    wr(8'h0C, 8'h83);
    wr(8'h04, 8'h5A);
    rd(8'h04, 8'h5A, "divisor high");
    wr(8'h04, 8'h00);
    wr(8'h0C, 8'h03);
    rd(8'h04, 8'h00, "enable mask");
    apb(1'b0, 8'h0D, 8'h00);
    chk("slverr", 32'h1, {31'h0, serr});
    $display("test registers done");
    for (i = 0; i < 5; i = i + 1)
    begin
      n = (i == 4) ? 8 : i;
      wr(8'h10, n[7:0]);
      idle(3);
      chk("term ready", {31'h0, !n[0]}, {31'h0, tr_n});
      chk("send req", {31'h0, !n[1]}, {31'h0, rq_n});
      chk("irq enable", {31'h0, n[3]}, {31'h0, irq_oe});
    end
    wr(8'h0C, 8'h43);
    idle(3);
    chk("break", 32'h0, {31'h0, txd});
    wr(8'h0C, 8'h03);
    idle(3);
    chk("mark", 32'h1, {31'h0, txd});
    $display("test modem lines done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h0C, fmt[i]);
      rd(8'h0C, fmt[i], "format");
      e = frame(fmt[i], 8'hB4 + i[7:0]);
      fork
        modem_peer_i.grab(nb, bits);
        wr(8'h00, 8'hB4 + i[7:0]);
      join
      chk("tx frame", {20'h0, e}, {20'h0, bits});
      idle(40);
    end
    $display("test transmit formats done");
    wr(8'h0C, 8'h1B);
    wr(8'h04, 8'h05);
    e = frame(8'h1B, 8'h3C);
    modem_peer_i.send(e ^ 12'h200, nb);
    rd(8'h08, 8'h06, "ident line");
    apb(1'b0, 8'h14, 8'h00);
    rd(8'h08, 8'h04, "ident data");
    rd(8'h00, 8'h3C, "rx data");
    rd(8'h08, 8'h01, "ident none");
    wr(8'h04, 8'h02);
    rd(8'h08, 8'h02, "ident thre");
    rd(8'h08, 8'h01, "thre clear");
    wr(8'h04, 8'h08);
    @(posedge ref_clk_in);
    modem_peer_i.cts_n_out <= 1'b0;
    idle(6);
    rd(8'h08, 8'h00, "ident modem");
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, 8'h18, 8'h00);
    rd(8'h08, 8'h01, "modem clear");
    $display("test interrupts done");
    wr(8'h04, 8'h01);
    wr(8'h0C, 8'h03);
    wr(8'h08, 8'h41);
    rd(8'h08, 8'hC1, "fifo on");
    e = frame(8'h03, 8'h6E);
    modem_peer_i.send(e, nb);
    idle(600);
    rd(8'h08, 8'hC1, "early");
    idle(120);
    rd(8'h08, 8'hCC, "timeout");
    rd(8'h00, 8'h6E, "fifo data");
    rd(8'h08, 8'hC1, "timeout clear");
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h01, "fifo off");
    $display("test fifo timeout done");
    test_done;
  end
endmodule
bind serial_port serial_port_asserts #(.ADDR_W(ADDR_W)) serial_port_asserts_i (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .txd_out(txd_out),
  .terminal_ready_n_out(terminal_ready_n_out),
  .request_to_send_n_out(request_to_send_n_out), .irq_oe_out(irq_oe_out));
